// File: src/axr_pkg.sv
// constants, register map and carrier types of the auxiliary result bank
// assumes a 32-bit avalon-mm host using byte addresses
package axr_pkg;

   // conversion sources, one per result register pair
   localparam int AXR_NSRC = 13;
   localparam int SRC_BATV = 0;
   localparam int SRC_ISNS = 1;
   localparam int SRC_CHGIN = 2;
   localparam int SRC_BID1 = 3;
   localparam int SRC_THR1 = 4;
   localparam int SRC_THR2 = 5;
   localparam int SRC_BID2 = 6;
   localparam int SRC_CH5 = 7;
   localparam int SRC_LCHG = 8;
   localparam int SRC_SCHG = 9;
   localparam int SRC_LBAT = 10;
   localparam int SRC_CH6 = 11;
   localparam int SRC_GPS = 12;

   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_BATTERY_VOLTAGE = 14'h0714;
   localparam logic [13:0] IDX_CURRENT_SENSE = 14'h0716;
   localparam logic [13:0] IDX_CHARGER_INPUT = 14'h0718;
   localparam logic [13:0] IDX_BATTERY_ID_ONE = 14'h071a;
   localparam logic [13:0] IDX_THERMAL_ONE = 14'h071c;
   localparam logic [13:0] IDX_THERMAL_TWO = 14'h071e;
   localparam logic [13:0] IDX_BATTERY_ID_TWO = 14'h0720;
   localparam logic [13:0] IDX_CHANNEL_FIVE = 14'h0722;
   localparam logic [13:0] IDX_LINEAR_WAKE = 14'h0724;
   localparam logic [13:0] IDX_SWITCH_WAKE = 14'h0726;
   localparam logic [13:0] IDX_LOW_BATTERY = 14'h0728;
   localparam logic [13:0] IDX_CHANNEL_SIX = 14'h072a;
   localparam logic [13:0] IDX_GPS_READY = 14'h072c;
   localparam logic [13:0] IDX_GPS_DATA = 14'h072e;
   localparam logic [13:0] IDX_GPS_LOW_BIT = 14'h0730;

   // field layout
   localparam int READY_BIT = 15;
   localparam int GPS_LOW_BIT_POS = 15;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // value width masks: 15-bit results, 12-bit low battery, 17-bit gps
   localparam logic [16:0] MASK_15 = 17'h07fff;
   localparam logic [16:0] MASK_12 = 17'h00fff;
   localparam logic [16:0] MASK_17 = 17'h1ffff;

   // one source's converter events: start clears ready, done loads value
   typedef struct packed {
      logic start;
      logic done;
      logic [16:0] value;
   } axr_conv_t;

endpackage

// File: src/axr_result_bank.sv
// read-only result register bank of the auxiliary measurement converter
// assumes converter events synchronous to clk and an avalon-mm master
// that holds its request until it samples waitrequest low
//
// Function
// R01 - battery voltage register shows ready in bit 15 (1 = valid) and value in 14:0.
// R02 - current sense register shows its own ready in bit 15 and value in 14:0.
// R03 - charger input register (channel 2) shows ready in bit 15 and value in 14:0.
// R04 - first battery id register (channel 3) shows ready in bit 15 and value in 14:0.
// R05 - second battery id register is separate with its own ready and 15-bit value.
// R06 - first thermal register (channel 4) shows ready in bit 15 and value in 14:0.
// R07 - second thermal register is separate with its own ready and 15-bit value.
// R08 - channel five register shows ready in bit 15 and value in 14:0.
// R09 - channel six register shows ready in bit 15 and value in 14:0.
// R10 - linear charger wake register shows ready in bit 15 and value in 14:0.
// R11 - switching charger wake register shows its own ready and value in 14:0.
// R12 - low battery register shows ready in bit 15, value in 11:0, bits 14:12 zero.
// R13 - gps ready flag sits alone in bit 15 of its own register.
// R14 - gps data word register holds 16 bits of the gps result in 15:0.
// R15 - every result register reads zero after reset.
// R16 - bit 15 of the register after the gps data word holds the gps result lsb.
// R17 - ready clears at conversion start, sets with its data update; reads have no side effects.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module axr_result_bank (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire axr_pkg::axr_conv_t [axr_pkg::AXR_NSRC-1:0] conv_evt,
   output logic [axr_pkg::AXR_NSRC-1:0] ready_flags
);
   import axr_pkg::*;

   logic [AXR_NSRC-1:0] ready_reg;
   logic [16:0] value_reg [AXR_NSRC];
   logic waitreq_reg;
   logic [31:0] rdata_reg;
   logic [15:0] word_next;
   logic [13:0] idx;
   logic aligned;
   logic req;

   assign idx = avs_address[15:2];
   assign aligned = (avs_address[1:0] == 2'b00);
   assign req = avs_read | avs_write;

   // per-source ready flag and held value
   for (genvar i = 0; i < AXR_NSRC; i++) begin : g_src
      localparam logic [16:0] VMASK = (i == SRC_LBAT) ? MASK_12 :
                                      (i == SRC_GPS) ? MASK_17 : MASK_15;

      // done beats start in the same cycle so a finished result is never lost
      always_ff @(posedge clk) begin
         if (rst) begin
            ready_reg[i] <= 1'b0; // [R15]
         end else if (conv_evt[i].done) begin
            ready_reg[i] <= 1'b1; // [R17]
         end else if (conv_evt[i].start) begin
            ready_reg[i] <= 1'b0; // [R17]
         end
      end

      // value loads only with done, trimmed to the source's width
      always_ff @(posedge clk) begin
         if (rst) begin
            value_reg[i] <= 17'h00000; // [R15]
         end else if (conv_evt[i].done) begin
            value_reg[i] <= conv_evt[i].value & VMASK; // [R12]
         end
      end
   end

   // readback word per register; unmapped or misaligned reads give zero
   always_comb begin
      word_next = RESULT_RESET;
      if (aligned) begin
         unique case (idx)
            IDX_BATTERY_VOLTAGE: begin
               word_next = {ready_reg[SRC_BATV], value_reg[SRC_BATV][14:0]}; // [R01]
            end
            IDX_CURRENT_SENSE: begin
               word_next = {ready_reg[SRC_ISNS], value_reg[SRC_ISNS][14:0]}; // [R02]
            end
            IDX_CHARGER_INPUT: begin
               word_next = {ready_reg[SRC_CHGIN], value_reg[SRC_CHGIN][14:0]}; // [R03]
            end
            IDX_BATTERY_ID_ONE: begin
               word_next = {ready_reg[SRC_BID1], value_reg[SRC_BID1][14:0]}; // [R04]
            end
            IDX_THERMAL_ONE: begin
               word_next = {ready_reg[SRC_THR1], value_reg[SRC_THR1][14:0]}; // [R06]
            end
            IDX_THERMAL_TWO: begin
               word_next = {ready_reg[SRC_THR2], value_reg[SRC_THR2][14:0]}; // [R07]
            end
            IDX_BATTERY_ID_TWO: begin
               word_next = {ready_reg[SRC_BID2], value_reg[SRC_BID2][14:0]}; // [R05]
            end
            IDX_CHANNEL_FIVE: begin
               word_next = {ready_reg[SRC_CH5], value_reg[SRC_CH5][14:0]}; // [R08]
            end
            IDX_LINEAR_WAKE: begin
               word_next = {ready_reg[SRC_LCHG], value_reg[SRC_LCHG][14:0]}; // [R10]
            end
            IDX_SWITCH_WAKE: begin
               word_next = {ready_reg[SRC_SCHG], value_reg[SRC_SCHG][14:0]}; // [R11]
            end
            IDX_LOW_BATTERY: begin
               word_next = {ready_reg[SRC_LBAT], 3'b000, value_reg[SRC_LBAT][11:0]}; // [R12]
            end
            IDX_CHANNEL_SIX: begin
               word_next = {ready_reg[SRC_CH6], value_reg[SRC_CH6][14:0]}; // [R09]
            end
            IDX_GPS_READY: begin
               word_next = {ready_reg[SRC_GPS], 15'h0000}; // [R13]
            end
            IDX_GPS_DATA: begin
               word_next = value_reg[SRC_GPS][16:1]; // [R14]
            end
            IDX_GPS_LOW_BIT: begin
               word_next = {value_reg[SRC_GPS][0], 15'h0000}; // [R16]
            end
            default: begin
               word_next = RESULT_RESET;
            end
         endcase
      end
   end

   // one wait state: answer lands the cycle after the request is seen,
   // then waitrequest rises again so a held request is not answered twice
   always_ff @(posedge clk) begin
      if (rst) begin
         waitreq_reg <= 1'b1;
      end else if (req && waitreq_reg) begin
         waitreq_reg <= 1'b0;
      end else begin
         waitreq_reg <= 1'b1;
      end
   end

   // read data captured with the answer; writes to this read-only bank
   // are acknowledged and dropped, and no read touches the flags
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 32'h00000000; // [R15]
      end else if (avs_read && waitreq_reg) begin
         rdata_reg <= {16'h0000, word_next}; // [R17]
      end
   end

   // flags exported so the converter sequencer can see what is pending
   always_ff @(posedge clk) begin
      if (rst) begin
         ready_flags <= '0;
      end else begin
         ready_flags <= ready_reg;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = waitreq_reg;

   // shadow of the last gps result taken straight from the converter, so the
   // split readback is checked against the input rather than against value_reg
   logic [16:0] gps_seen_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         gps_seen_reg <= 17'h00000;
      end else if (conv_evt[SRC_GPS].done) begin
         gps_seen_reg <= conv_evt[SRC_GPS].value;
      end
   end

   // assertions
   sequence s_read_of(logic [13:0] ix);
      avs_read && waitreq_reg && aligned && idx == ix;
   endsequence

   // answer: waitrequest low for exactly one cycle, then high again
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_batv_readback: assert property (@(posedge clk) disable iff (rst) // [R01]
      s_read_of(IDX_BATTERY_VOLTAGE) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_BATV]), $past(value_reg[SRC_BATV][14:0])})
      else $error("battery voltage readback wrong");

   a_isns_readback: assert property (@(posedge clk) disable iff (rst) // [R02]
      s_read_of(IDX_CURRENT_SENSE) |=>
      avs_readdata[15] == $past(ready_reg[SRC_ISNS]) && !avs_waitrequest)
      else $error("current sense ready readback wrong");

   a_lbat_unused_zero: assert property (@(posedge clk) disable iff (rst) // [R12]
      s_read_of(IDX_LOW_BATTERY) |=> avs_readdata[14:12] == 3'b000 && avs_readdata[31:16] == 16'h0000)
      else $error("low battery unused bits not zero");

   a_gps_flag_alone: assert property (@(posedge clk) disable iff (rst) // [R13]
      s_read_of(IDX_GPS_READY) |=>
      avs_readdata[14:0] == 15'h0000 && avs_readdata[15] == $past(ready_reg[SRC_GPS]))
      else $error("gps ready register has stray bits");

   // a read taken any time after the update, not only the cycle after
   a_gps_split: assert property (@(posedge clk) disable iff (rst) // [R16]
      s_read_of(IDX_GPS_LOW_BIT) |=>
      avs_readdata[15:0] == {$past(gps_seen_reg[0]), 15'h0000})
      else $error("gps low bit not from result lsb");

   a_gps_word: assert property (@(posedge clk) disable iff (rst) // [R14]
      s_read_of(IDX_GPS_DATA) |=> avs_readdata[15:0] == $past(gps_seen_reg[16:1]))
      else $error("gps data word wrong");

   a_gps_load: assert property (@(posedge clk) disable iff (rst) // [R14]
      conv_evt[SRC_GPS].done |=>
      ready_reg[SRC_GPS] && value_reg[SRC_GPS] == $past(conv_evt[SRC_GPS].value))
      else $error("gps result not loaded with its flag");

   a_done_sets_ready: assert property (@(posedge clk) disable iff (rst) // [R17]
      conv_evt[SRC_CH5].done |=> ready_reg[SRC_CH5] && value_reg[SRC_CH5][14:0] ==
      $past(conv_evt[SRC_CH5].value[14:0]))
      else $error("done did not set ready with data");

   a_start_clears: assert property (@(posedge clk) disable iff (rst) // [R17]
      conv_evt[SRC_THR2].start && !conv_evt[SRC_THR2].done |=> !ready_reg[SRC_THR2])
      else $error("start did not clear ready");

   a_read_no_effect: assert property (@(posedge clk) disable iff (rst) // [R17]
      avs_read && !conv_evt[SRC_BID2].start && !conv_evt[SRC_BID2].done |=>
      $stable(ready_reg[SRC_BID2]))
      else $error("read changed a ready flag");

   a_reset_zero: assert property (@(posedge clk) // [R15]
      rst |=> ready_reg == '0 && avs_readdata == 32'h00000000 && avs_waitrequest)
      else $error("bank not zero after reset");

   a_answer_time: assert property (@(posedge clk) disable iff (rst) // [R17]
      req && waitreq_reg |=> s_answer)
      else $error("answer not one cycle after request");

   // field placement of each remaining result word on readback
   a_isns_value: assert property (@(posedge clk) disable iff (rst) // [R02]
      s_read_of(IDX_CURRENT_SENSE) |=>
      avs_readdata[14:0] == $past(value_reg[SRC_ISNS][14:0]))
      else $error("current sense value readback wrong");

   a_chgin_readback: assert property (@(posedge clk) disable iff (rst) // [R03]
      s_read_of(IDX_CHARGER_INPUT) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_CHGIN]), $past(value_reg[SRC_CHGIN][14:0])})
      else $error("charger input readback wrong");

   a_bid1_readback: assert property (@(posedge clk) disable iff (rst) // [R04]
      s_read_of(IDX_BATTERY_ID_ONE) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_BID1]), $past(value_reg[SRC_BID1][14:0])})
      else $error("first battery id readback wrong");

   a_bid2_readback: assert property (@(posedge clk) disable iff (rst) // [R05]
      s_read_of(IDX_BATTERY_ID_TWO) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_BID2]), $past(value_reg[SRC_BID2][14:0])})
      else $error("second battery id readback wrong");

   a_thr1_readback: assert property (@(posedge clk) disable iff (rst) // [R06]
      s_read_of(IDX_THERMAL_ONE) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_THR1]), $past(value_reg[SRC_THR1][14:0])})
      else $error("first thermal readback wrong");

   a_thr2_readback: assert property (@(posedge clk) disable iff (rst) // [R07]
      s_read_of(IDX_THERMAL_TWO) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_THR2]), $past(value_reg[SRC_THR2][14:0])})
      else $error("second thermal readback wrong");

   a_ch5_readback: assert property (@(posedge clk) disable iff (rst) // [R08]
      s_read_of(IDX_CHANNEL_FIVE) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_CH5]), $past(value_reg[SRC_CH5][14:0])})
      else $error("channel five readback wrong");

   a_ch6_readback: assert property (@(posedge clk) disable iff (rst) // [R09]
      s_read_of(IDX_CHANNEL_SIX) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_CH6]), $past(value_reg[SRC_CH6][14:0])})
      else $error("channel six readback wrong");

   a_lwake_readback: assert property (@(posedge clk) disable iff (rst) // [R10]
      s_read_of(IDX_LINEAR_WAKE) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_LCHG]), $past(value_reg[SRC_LCHG][14:0])})
      else $error("linear charger wake readback wrong");

   a_swake_readback: assert property (@(posedge clk) disable iff (rst) // [R11]
      s_read_of(IDX_SWITCH_WAKE) |=>
      avs_readdata[15:0] == {$past(ready_reg[SRC_SCHG]), $past(value_reg[SRC_SCHG][14:0])})
      else $error("switching charger wake readback wrong");

   a_lbat_value: assert property (@(posedge clk) disable iff (rst) // [R12]
      s_read_of(IDX_LOW_BATTERY) |=> avs_readdata[15:0] ==
      {$past(ready_reg[SRC_LBAT]), 3'b000, $past(value_reg[SRC_LBAT][11:0])})
      else $error("low battery readback wrong");

   // upper input bits must not survive into the 12-bit low battery value
   a_lbat_mask: assert property (@(posedge clk) disable iff (rst) // [R12]
      conv_evt[SRC_LBAT].done |=> value_reg[SRC_LBAT][16:12] == 5'h00)
      else $error("low battery value not trimmed to 12 bits");

   a_done_wins: assert property (@(posedge clk) disable iff (rst) // [R17]
      conv_evt[SRC_BATV].start && conv_evt[SRC_BATV].done |=> ready_reg[SRC_BATV])
      else $error("start beat done in the same cycle");

   a_start_keeps_value: assert property (@(posedge clk) disable iff (rst) // [R17]
      conv_evt[SRC_THR2].start && !conv_evt[SRC_THR2].done |=>
      $stable(value_reg[SRC_THR2]))
      else $error("start disturbed the held value");

   a_thr1_start_clears: assert property (@(posedge clk) disable iff (rst) // [R06]
      conv_evt[SRC_THR1].start && !conv_evt[SRC_THR1].done |=> !ready_reg[SRC_THR1])
      else $error("thermal one start did not clear ready");

   // a flag may only rise with a done pulse of its own source
   a_ready_needs_done: assert property (@(posedge clk) disable iff (rst) // [R17]
      !ready_reg[SRC_CH6] && !conv_evt[SRC_CH6].done |=> !ready_reg[SRC_CH6])
      else $error("channel six flag rose without a done pulse");

   // the bank is read-only: a write must leave flag and value alone
   a_write_no_effect: assert property (@(posedge clk) disable iff (rst) // [R01]
      avs_write && !conv_evt[SRC_BATV].start && !conv_evt[SRC_BATV].done |=>
      $stable(ready_reg[SRC_BATV]) && $stable(value_reg[SRC_BATV]))
      else $error("write changed a read-only result");

   a_read_holds: assert property (@(posedge clk) disable iff (rst) // [R17]
      !(avs_read && waitreq_reg) |=> $stable(avs_readdata))
      else $error("read data moved without a read");

   a_flags_follow: assert property (@(posedge clk) disable iff (rst) // [R17]
      1'b1 |=> ready_flags == $past(ready_reg))
      else $error("exported flags not one cycle behind");

   a_reset_values: assert property (@(posedge clk) // [R15]
      rst |=> value_reg[SRC_GPS] == 17'h00000 && gps_seen_reg == 17'h00000 &&
      ready_flags == '0)
      else $error("held values not cleared by reset");

   a_single_answer: assert property (@(posedge clk) disable iff (rst) // [R17]
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

endmodule

// File: dv/tb_aux_adc_result_registers.sv
// self-checking bench for the auxiliary converter result bank
// assumes axr_pkg is compiled first; the bench drives bus and converter events itself
`timescale 1ns/1ps
module tb_aux_adc_result_registers;
   import axr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] avs_address = 16'h0000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   axr_conv_t [AXR_NSRC-1:0] conv_evt = '0;
   logic [AXR_NSRC-1:0] ready_flags;
   int n_errors = 0;
   int n_checks = 0;
   int m_val [AXR_NSRC];
   int m_rdy [AXR_NSRC];
   logic [31:0] seed = 32'ha196;
   logic [31:0] rdata;

   axr_result_bank i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .conv_evt(conv_evt), .ready_flags(ready_flags));

   // 10 mhz clock
   always #50 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   // expected read word from the model; unmapped and misaligned read zero
   function automatic logic [31:0] exp_reg(input logic [15:0] a);
      int idx;
      int s;
      idx = int'(a[15:2]);
      s = (idx - 16'h0714) / 2;
      if (a[1:0] != 2'b00) return 32'h00000000;
      if (idx == 16'h072e) return 32'(m_val[SRC_GPS] >> 1);
      if (idx == 16'h0730) return 32'((m_val[SRC_GPS] & 1) << 15);
      if (idx == 16'h072c) return 32'(m_rdy[SRC_GPS] << 15);
      if (idx >= 16'h0714 && idx < 16'h072c && idx % 2 == 0) begin
         return 32'((m_rdy[s] << 15) | m_val[s]);
      end
      return 32'h00000000;
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flags(input logic [AXR_NSRC-1:0] got, input logic [AXR_NSRC-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: flags got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic [15:0] addr, input logic wr);
      @(posedge clk);
      seed = lfsr(seed);
      avs_address <= addr;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= seed;
      avs_byteenable <= seed[3:0];
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_all();
      logic [AXR_NSRC-1:0] f;
      f = '0;
      for (int i = 0; i < 16; i++) begin
         bus(16'((16'h0714 + 2 * i) << 2), 1'b0);
         cmp(rdata, exp_reg(16'((16'h0714 + 2 * i) << 2))); // result words
      end
      bus(16'h1c52, 1'b0);
      cmp(rdata, 32'h00000000); // misaligned reads zero
      for (int s = 0; s < AXR_NSRC; s++) f[s] = m_rdy[s][0];
      cmp_flags(ready_flags, f); // flag copy
   endtask

   // random start and done pulses on all sources in one cycle; done wins
   task automatic evt(input int p_done);
      axr_conv_t [AXR_NSRC-1:0] v;
      logic [16:0] msk;
      for (int s = 0; s < AXR_NSRC; s++) begin
         seed = lfsr(seed);
         v[s].start = seed[0];
         v[s].done = (int'(seed[7:4]) < p_done);
         v[s].value = seed[31:15];
         msk = (s == SRC_LBAT) ? 17'h00fff : (s == SRC_GPS) ? 17'h1ffff : 17'h07fff;
         if (v[s].done) begin
            m_rdy[s] = 1;
            m_val[s] = int'(v[s].value & msk);
         end else if (v[s].start) begin
            m_rdy[s] = 0;
         end
      end
      @(posedge clk);
      conv_evt <= v;
      @(posedge clk);
      conv_evt <= '0;
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int s = 0; s < AXR_NSRC; s++) begin
         m_val[s] = 0;
         m_rdy[s] = 0;
      end
   endtask

   task automatic report_and_stop();
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // main sequence: reset values, conversions, ignored write, mid-run reset
   initial begin
      do_reset();
      rd_all(); // all zero out of reset
      for (int r = 0; r < 24; r++) begin
         evt((r < 6) ? 16 : (r % 5 == 4) ? 0 : 6);
         rd_all(); // read back every word after this batch of events
         if (r == 12) begin
            bus({IDX_BATTERY_VOLTAGE, 2'b00}, 1'b1);
            rd_all(); // write has no effect on read-only words
            do_reset();
            rd_all(); // all zero after a second reset
         end
      end
      report_and_stop();
   end

   // watchdog well beyond the roughly 1400 cycles the run needs
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
endmodule
